// File: src/tap_cfg.svh
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH
// instruction register width and captured value
`define IR_W 4
`define IR_CAPTURE 4'h1
`define IR_RESET_VALUE 4'hF
// debug opcodes
`define OP_DEBUG_A 4'h8
`define OP_DEBUG_B 4'h9
`define OP_DEBUG_C 4'hA
`define OP_DEBUG_D 4'hB
// debug scan chain widths
`define CPU_CHAIN_W 16
`define BP_CHAIN_W 36
`define BP_ADDR_W 16
`define COMM_W 8
`define COMM_DIRTY_BIT 7
`endif

// File: src/tap_pkg.sv
package tap_pkg;
   // tap controller states, gray-ish along the usual path
   typedef enum logic [3:0] {
      ST_RESET = 4'hF, ST_IDLE = 4'hC, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
      ST_SHIFT_DR = 4'h2, ST_EXIT1_DR = 4'h1, ST_PAUSE_DR = 4'h3, ST_EXIT2_DR = 4'h0,
      ST_UPD_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'hE, ST_SHIFT_IR = 4'hA,
      ST_EXIT1_IR = 4'h9, ST_PAUSE_IR = 4'hB, ST_EXIT2_IR = 4'h8, ST_UPD_IR = 4'hD
   } tap_state_e;

   // break point unit configuration
   typedef struct packed {
      logic flow_break;
      logic single_step;
      logic [1:0] mode;
      logic [15:0] addr_c;
      logic [15:0] addr_d;
   } bp_cfg_s;

   // enable gating inputs
   typedef struct packed {
      logic tap_enable_fuse;
      logic tap_disable_bit;
      logic debug_enable_fuse;
      logic lock_bit_one;
      logic lock_bit_two;
   } sec_s;
endpackage

// File: src/tap_debug_access.sv
`timescale 1ns/1ps
`include "tap_cfg.svh"
module tap_debug_access (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic tms_pin,
   input wire logic tck_pin,
   input wire logic tdi_pin,
   output logic tdo_out,
   output logic tdo_oe_n,
   input wire tap_pkg::sec_s sec,
   input wire logic chip_erased,
   input wire logic [`COMM_W-2:0] comm_from_cpu,
   input wire logic comm_write,
   input wire logic [`CPU_CHAIN_W-1:0] cpu_chain_capture,
   output logic tap_active,
   output logic pins_pullup,
   output logic debug_active,
   output logic debug_fuse_prog_ok,
   output logic [`IR_W-1:0] instr,
   output logic [`CPU_CHAIN_W-1:0] cpu_inject,
   output logic cpu_inject_stb,
   output logic idle_run,
   output tap_pkg::bp_cfg_s bp_cfg,
   output logic [`COMM_W-1:0] comm_to_cpu
);

   // ----------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------
   logic [1:0] tck_sync_reg, tms_sync_reg, tdi_sync_reg;
   logic tck_prev_reg;
   logic tck_rise, tck_fall;

   // two flops per pin; only three input pins (tck, tms, tdi) are synchronised
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tck_sync_reg <= 2'h0;
         tms_sync_reg <= 2'h3;
         tdi_sync_reg <= 2'h3;
         tck_prev_reg <= 1'b0;
      end
      else
      begin
         tck_sync_reg <= {tck_sync_reg[0], tck_pin};
         tms_sync_reg <= {tms_sync_reg[0], tms_pin};
         tdi_sync_reg <= {tdi_sync_reg[0], tdi_pin};
         tck_prev_reg <= tck_sync_reg[1];
      end
   end

   assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
   assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;

   // ----------------------------------------
   // enable gating
   // ----------------------------------------
   logic tap_en, dbg_en;
   assign tap_en = sec.tap_enable_fuse & ~sec.tap_disable_bit;
   assign dbg_en = tap_en & sec.debug_enable_fuse & ~sec.lock_bit_one & ~sec.lock_bit_two;

   // status outputs
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tap_active <= 1'b0;
         pins_pullup <= 1'b0;
         debug_active <= 1'b0;
         debug_fuse_prog_ok <= 1'b0;
      end
      else
      begin
         tap_active <= tap_en;
         pins_pullup <= tap_en;
         debug_active <= dbg_en;
         debug_fuse_prog_ok <= chip_erased | ~(sec.lock_bit_one | sec.lock_bit_two);
      end
   end

   // ----------------------------------------
   // tap state machine
   // ----------------------------------------
   tap_pkg::tap_state_e state_reg, state_next;
   logic tms;
   assign tms = tms_sync_reg[1];

   // next state from tms
   always_comb
   begin
      case (state_reg)
         tap_pkg::ST_RESET: state_next = tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE: state_next = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR: state_next = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR: state_next = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_SHIFT_DR: state_next = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_EXIT1_DR: state_next = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_PAUSE_DR: state_next = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_EXIT2_DR: state_next = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_UPD_DR: state_next = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR: state_next = tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR: state_next = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_SHIFT_IR: state_next = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_EXIT1_IR: state_next = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_PAUSE_IR: state_next = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_EXIT2_IR: state_next = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_UPD_IR: state_next = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         default: state_next = tap_pkg::ST_RESET;
      endcase
   end

   // state register, held in reset while disabled
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         state_reg <= tap_pkg::ST_RESET;
      else if (!tap_en)
         state_reg <= tap_pkg::ST_RESET;
      else if (tck_rise)
         state_reg <= state_next;
   end

   // ----------------------------------------
   // instruction register
   // ----------------------------------------
   logic [`IR_W-1:0] ir_shift_reg;
   logic is_dbg_op;

   // capture, shift lsb first, update; the reset state reloads both registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ir_shift_reg <= `IR_CAPTURE;
         instr <= `IR_RESET_VALUE;
      end
      else if (state_reg == tap_pkg::ST_RESET)
      begin
         ir_shift_reg <= `IR_CAPTURE;
         instr <= `IR_RESET_VALUE;
      end
      else if (tck_rise)
      begin
         if (state_reg == tap_pkg::ST_CAP_IR)
            ir_shift_reg <= `IR_CAPTURE;
         else if (state_reg == tap_pkg::ST_SHIFT_IR)
            ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[`IR_W-1:1]};
         else if (state_reg == tap_pkg::ST_UPD_IR)
            instr <= ir_shift_reg;
      end
   end

   assign is_dbg_op = dbg_en && instr >= `OP_DEBUG_A && instr <= `OP_DEBUG_D;

   // ----------------------------------------
   // debug data registers
   // ----------------------------------------
   logic [`BP_CHAIN_W-1:0] dr_shift_reg;
   logic dr_lsb;
   logic [`COMM_W-1:0] comm_reg;
   logic host_read;

   // capture parallel values, shift lsb first
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         dr_shift_reg <= '0;
      else if (tck_rise && is_dbg_op)
      begin
         if (state_reg == tap_pkg::ST_CAP_DR)
         begin
            case (instr)
               `OP_DEBUG_A: dr_shift_reg <= {{(`BP_CHAIN_W-`CPU_CHAIN_W){1'b0}}, cpu_chain_capture};
               `OP_DEBUG_B: dr_shift_reg <= bp_cfg;
               `OP_DEBUG_C: dr_shift_reg <= {{(`BP_CHAIN_W-`COMM_W){1'b0}}, comm_reg};
               default: dr_shift_reg <= '0;
            endcase
         end
         else if (state_reg == tap_pkg::ST_SHIFT_DR)
         begin
            case (instr)
               `OP_DEBUG_A: dr_shift_reg[`CPU_CHAIN_W-1:0] <=
                  {tdi_sync_reg[1], dr_shift_reg[`CPU_CHAIN_W-1:1]};
               `OP_DEBUG_C: dr_shift_reg[`COMM_W-1:0] <= {tdi_sync_reg[1], dr_shift_reg[`COMM_W-1:1]};
               default: dr_shift_reg <= {tdi_sync_reg[1], dr_shift_reg[`BP_CHAIN_W-1:1]};
            endcase
         end
      end
   end

   assign dr_lsb = dr_shift_reg[0];
   assign host_read = tck_rise && is_dbg_op && instr == `OP_DEBUG_C && state_reg == tap_pkg::ST_UPD_DR;

   // update latched outputs in Update-DR; bp_cfg also clears while debug is disabled
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cpu_inject <= '0;
         cpu_inject_stb <= 1'b0;
         bp_cfg <= '0;
         comm_to_cpu <= '0;
      end
      else
      begin
         cpu_inject_stb <= 1'b0;
         if (!dbg_en)
            bp_cfg <= '0;
         else if (tck_rise && is_dbg_op && state_reg == tap_pkg::ST_UPD_DR)
         begin
            case (instr)
               `OP_DEBUG_A:
               begin
                  cpu_inject <= dr_shift_reg[`CPU_CHAIN_W-1:0];
                  cpu_inject_stb <= 1'b1;
               end
               `OP_DEBUG_B: bp_cfg <= dr_shift_reg;
               `OP_DEBUG_C: comm_to_cpu <= dr_shift_reg[`COMM_W-1:0];
               default: cpu_inject_stb <= 1'b0;
            endcase
         end
      end
   end

   // cpu to debugger byte with dirty flag; set wins over clear
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         comm_reg <= '0;
      else if (comm_write)
         comm_reg <= {1'b1, comm_from_cpu};
      else if (host_read)
         comm_reg[`COMM_DIRTY_BIT] <= 1'b0;
   end

   // run-test/idle action indicator
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         idle_run <= 1'b0;
      else
         idle_run <= is_dbg_op && state_reg == tap_pkg::ST_IDLE;
   end

   // ----------------------------------------
   // tdo output, changes on falling tck
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tdo_out <= 1'b1;
         tdo_oe_n <= 1'b1;
      end
      else if (!tap_en)
      begin
         tdo_out <= 1'b1;
         tdo_oe_n <= 1'b1;
      end
      else if (tck_fall)
      begin
         if (state_reg == tap_pkg::ST_SHIFT_IR)
         begin
            tdo_out <= ir_shift_reg[0];
            tdo_oe_n <= 1'b0;
         end
         else if (state_reg == tap_pkg::ST_SHIFT_DR)
         begin
            tdo_out <= is_dbg_op ? dr_lsb : 1'b0;
            tdo_oe_n <= 1'b0;
         end
         else
         begin
            tdo_out <= 1'b1;
            tdo_oe_n <= 1'b1;
         end
      end
   end

endmodule

// File: dv/tap_debug_access_sva.sv
`timescale 1ns/1ps
`include "tap_cfg.svh"
module tap_debug_access_sva (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic tck_pin,
   input wire logic tdo_out,
   input wire logic tdo_oe_n,
   input wire tap_pkg::sec_s sec,
   input wire logic chip_erased,
   input wire logic tap_active,
   input wire logic debug_active,
   input wire logic debug_fuse_prog_ok,
   input wire logic [`IR_W-1:0] instr,
   input wire logic idle_run,
   input wire tap_pkg::bp_cfg_s bp_cfg,
   input wire logic [`COMM_W-1:0] comm_to_cpu
);
   // ------------------------------------
   // port relations
   // ------------------------------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   property p_fuse_off;
      !sec.tap_enable_fuse [*3] |-> instr == 4'hF && tdo_oe_n;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("tap not held in reset");
   property p_oe_active;
      !tdo_oe_n |-> tap_active;
   endproperty
   a_oe_active: assert property (p_oe_active) else $error("tdo driven while tap off");
   property p_debug;
      debug_active |-> $past(sec.tap_enable_fuse && sec.debug_enable_fuse && !sec.lock_bit_one && !sec.lock_bit_two);
   endproperty
   a_debug: assert property (p_debug) else $error("debug active without permission");
   property p_prog;
      (sec.lock_bit_one || sec.lock_bit_two) && !chip_erased |=> !debug_fuse_prog_ok;
   endproperty
   a_prog: assert property (p_prog) else $error("fuse programming allowed while locked");
   property p_tdo_edge;
      $changed(tdo_out) && tap_active && $past(tap_active) |-> !tck_pin;
   endproperty
   a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved outside tck low");
   property p_instr_upd;
      $changed(instr) && instr != 4'hF |-> tck_pin && tap_active;
   endproperty
   a_instr_upd: assert property (p_instr_upd) else $error("instruction latched off update");
   property p_dr_upd;
      ($changed(comm_to_cpu) || $changed(bp_cfg)) && tap_active |-> tck_pin || !debug_active;
   endproperty
   a_dr_upd: assert property (p_dr_upd) else $error("data output latched off update");
   property p_idle_run;
      idle_run |-> debug_active && instr[3:2] == 2'b10;
   endproperty
   a_idle_run: assert property (p_idle_run) else $error("idle action without debug opcode");
endmodule
bind tap_debug_access tap_debug_access_sva chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .tck_pin(tck_pin), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
   .sec(sec), .chip_erased(chip_erased), .tap_active(tap_active), .debug_active(debug_active),
   .debug_fuse_prog_ok(debug_fuse_prog_ok), .instr(instr), .idle_run(idle_run), .bp_cfg(bp_cfg),
   .comm_to_cpu(comm_to_cpu)
);

// File: dv/jtag_probe_model.sv
`timescale 1ns/1ps
module jtag_probe_model (
   output logic tck_pin,
   output logic tms_pin,
   output logic tdi_pin,
   input wire logic tdo_out,
   input wire logic tdo_oe_n
);
   // ------------------------------------
   // tester side of the test port
   // ------------------------------------
   // link clock stands still until a scan
   initial
   begin
      tck_pin = 1'b0;
      tms_pin = 1'b1;
      tdi_pin = 1'b0;
   end
   // one 125 ns tck period; a released tdo reads as pulled high
   task tick(input logic m, input logic d, output logic q);
      tms_pin = m;
      tdi_pin = d;
      #60;
      q = tdo_oe_n ? 1'b1 : tdo_out;
      #2.5 tck_pin = 1'b1;
      #62.5 tck_pin = 1'b0;
   endtask
   // walk to shift, move n bits lsb first, then update
   task scan(input logic ir, input int n, input logic [35:0] din, input logic idle, output logic [35:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b0, q);
      if (ir)
         tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b0, q);
      if (idle)
         tick(1'b0, 1'b0, q);
   endtask
   // five periods of tms high, then one low to settle in run-test/idle
   task reset5();
      logic q;
      repeat (5)
         tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
endmodule

// File: dv/jtag_tap_debug_access_tb.sv
`timescale 1ns/1ps
`include "tap_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module jtag_tap_debug_access_tb;
   // ------------------------------------
   // bench signals and instances
   // ------------------------------------
   logic clk_sys, arst_n, tms_pin, tck_pin, tdi_pin, tdo_out, tdo_oe_n, chip_erased, comm_write;
   logic tap_active, pins_pullup, debug_active, debug_fuse_prog_ok, cpu_inject_stb, idle_run;
   tap_pkg::sec_s sec;
   tap_pkg::bp_cfg_s bp_cfg;
   logic [`COMM_W-2:0] comm_from_cpu;
   logic [`COMM_W-1:0] comm_to_cpu;
   logic [`CPU_CHAIN_W-1:0] cpu_chain_capture, cpu_inject;
   logic [`IR_W-1:0] instr;
   logic [35:0] d;
   int n_errors = 0;
   int total_checks = 0;
   int n_stb = 0;
   tap_debug_access uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .tms_pin(tms_pin), .tck_pin(tck_pin), .tdi_pin(tdi_pin),
      .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .sec(sec), .chip_erased(chip_erased),
      .comm_from_cpu(comm_from_cpu), .comm_write(comm_write), .cpu_chain_capture(cpu_chain_capture),
      .tap_active(tap_active), .pins_pullup(pins_pullup), .debug_active(debug_active),
      .debug_fuse_prog_ok(debug_fuse_prog_ok), .instr(instr), .cpu_inject(cpu_inject),
      .cpu_inject_stb(cpu_inject_stb), .idle_run(idle_run), .bp_cfg(bp_cfg), .comm_to_cpu(comm_to_cpu)
   );
   jtag_probe_model probe (
      .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n)
   );
   // 100 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // count injection strobes, one per update
   always @(negedge clk_sys)
      if (cpu_inject_stb)
         n_stb++;
   // counts and verdict
   task stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // gating inputs {fuse, disable, debug fuse, lock one, lock two}
   task set_sec(input logic [4:0] v);
      @(negedge clk_sys) sec = v;
      repeat (3) @(negedge clk_sys);
   endtask
   // hang guard, about nine times the scan time
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      stop_test();
   end
   // main sequence
   initial
   begin
      arst_n = 1'b0;
      sec = 5'h00;
      chip_erased = 1'b0;
      comm_from_cpu = 7'h00;
      comm_write = 1'b0;
      cpu_chain_capture = 16'hA55A;
      repeat (10) @(negedge clk_sys);
      arst_n = 1'b1;
      `CHK(instr, 4'hF)
      `CHK(tdo_oe_n, 1'b1)
      set_sec(5'h14);
      `CHK(tap_active, 1'b1)
      `CHK(pins_pullup, 1'b1)
      `CHK(debug_active, 1'b1)
      probe.reset5();
      probe.scan(1'b1, 4, 36'hA, 1'b1, d);
      `CHK(d[3:0], 4'h1)
      `CHK(instr, 4'hA)
      @(negedge clk_sys) comm_from_cpu = 7'h35;
      comm_write = 1'b1;
      @(negedge clk_sys) comm_write = 1'b0;
      probe.scan(1'b0, 8, 36'hC3, 1'b1, d);
      `CHK(d[7:0], 8'hB5)
      `CHK(comm_to_cpu, 8'hC3)
      probe.scan(1'b0, 8, 36'h0, 1'b1, d);
      `CHK(d[7:0], 8'h35)
      probe.scan(1'b1, 4, 36'h8, 1'b1, d);
      probe.scan(1'b0, 16, 36'h1234, 1'b1, d);
      `CHK(d[15:0], 16'hA55A)
      `CHK(cpu_inject, 16'h1234)
      `CHK(n_stb, 1)
      probe.scan(1'b1, 4, 36'h9, 1'b0, d);
      probe.scan(1'b0, 36, 36'h987654321, 1'b1, d);
      `CHK(bp_cfg, 36'h987654321)
      `CHK(idle_run, 1'b1)
      probe.reset5();
      `CHK(instr, 4'hF)
      set_sec(5'h16);
      `CHK(debug_active, 1'b0)
      `CHK(bp_cfg, 36'h0)
      `CHK(debug_fuse_prog_ok, 1'b0)
      @(negedge clk_sys) chip_erased = 1'b1;
      repeat (3) @(negedge clk_sys);
      `CHK(debug_fuse_prog_ok, 1'b1)
      probe.scan(1'b1, 4, 36'h8, 1'b1, d);
      probe.scan(1'b0, 16, 36'hBEEF, 1'b1, d);
      `CHK(cpu_inject, 16'h1234)
      `CHK(d[15:0], 16'h0000)
      `CHK(n_stb, 1)
      set_sec(5'h1C);
      `CHK(tap_active, 1'b0)
      set_sec(5'h00);
      `CHK(instr, 4'hF)
      `CHK(tap_active, 1'b0)
      @(negedge clk_sys);
      arst_n = 1'b0;
      @(negedge clk_sys);
      `CHK(cpu_inject, 16'h0000)
      arst_n = 1'b1;
      set_sec(5'h14);
      probe.reset5();
      probe.scan(1'b1, 4, 36'h8, 1'b1, d);
      `CHK(d[3:0], 4'h1)
      `CHK(instr, 4'h8)
      stop_test();
   end
endmodule
